// file: irqd_map.svh
// Register offsets, field positions, reset values and timing counts of
// the interrupt request detection block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one clock.
`ifndef IRQD_MAP_SVH
`define IRQD_MAP_SVH
`define IRQD_NV 256
`define IRQD_OFS_CTRL 8'h00
`define IRQD_OFS_BASE 8'h04
`define IRQD_OFS_SENSE 8'h08
`define IRQD_OFS_SEL 8'h0C
`define IRQD_OFS_VREG 8'h10
`define IRQD_OFS_STAT 8'h14
`define IRQD_CTRL_DMA_POST 0
`define IRQD_CTRL_DTC_POST 1
`define IRQD_CTRL_FAST_EN 16
`define IRQD_NMI_TABLE 32'hFFFFFFF8
`define IRQD_BASE_RST 32'h00000000
`define IRQD_SENSE_RST 16'h0000
`define IRQD_PCLK_DIV 2'h1
`define IRQD_PIN_LO 8'h40
`define IRQD_DLY_LO 8'h40
`define IRQD_DLY_HI 8'h5F
`endif

// file: irqd_pkg.sv
// Types shared by the interrupt request detection block.
// Assumes nothing of its surroundings.
package irqd_pkg;
    // Detection kind of one vector number.
    typedef enum logic [2:0] {
        IRQD_RSV, IRQD_EDGE, IRQD_LEVEL, IRQD_PIN, IRQD_SER
    } irqd_kind_t;
    // Destination chosen by software for one vector.
    typedef enum logic [1:0] {
        IRQD_TO_CPU, IRQD_TO_DTC, IRQD_TO_DMA
    } irqd_dest_t;
endpackage

// file: irqd_det.sv
// One source detector: optional two-stage peripheral-clock delay,
// edge or level sensing and the pending flag.
// Assumes request lines synchronous to core_clk_in.
`timescale 1ns/10ps
module irqd_det (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic req_in,
    input irqd_pkg::irqd_kind_t kind_in,
    input wire logic [1:0] sense_in,
    input wire logic dly_in,
    input wire logic pclk_en_in,
    input wire logic clr_in,
    output logic pend_out
);
    logic s1_r, s2_r, prev_r, hold_r, pend_r;
    logic src, rise, fall, evt, lvl, is_lvl, set, pend_nxt, hold_nxt;

    // Delayed path samples only on peripheral clock enables.
    assign src = dly_in ? s2_r : req_in;
    assign rise = src & ~prev_r;
    assign fall = ~src & prev_r;
    // Pins take their sense field; 00 is low level.
    assign is_lvl = (kind_in == irqd_pkg::IRQD_LEVEL) |
                    ((kind_in == irqd_pkg::IRQD_PIN) & (sense_in == 2'h0));
    assign lvl = (kind_in == irqd_pkg::IRQD_PIN) ? ~src : src;
    assign evt = (kind_in == irqd_pkg::IRQD_PIN) ?
                 ((sense_in[0] & fall) | (sense_in[1] & rise)) : rise;
    // A held serial request re-sets the flag once it clears.
    assign set = evt | (hold_r & ~pend_r);
    // Set wins over clear; edge repeats while pending merge in.
    assign pend_nxt = (kind_in == irqd_pkg::IRQD_RSV) ? 1'b0 :
                      is_lvl ? lvl :
                      (set | (pend_r & ~clr_in));
    assign hold_nxt = (kind_in == irqd_pkg::IRQD_SER) &
                      ((evt & pend_r & ~clr_in) | (hold_r & pend_r));

    // Short sequential part; every flop resets to a constant.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            prev_r <= 1'b0;
            hold_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            if (pclk_en_in) begin
                s1_r <= req_in;
                s2_r <= s1_r;
            end
            prev_r <= src;
            hold_r <= hold_nxt;
            pend_r <= pend_nxt;
        end
    end
    assign pend_out = pend_r;
endmodule

// file: irqd_arb.sv
// Sequential winner search for one destination, one vector per clock.
// Assumes the caller sweeps scan_in from 0 to 255 and flags the end.
`timescale 1ns/10ps
module irqd_arb (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] scan_in,
    input wire logic wrap_in,
    input wire logic hit_in,
    input wire logic [3:0] prio_in,
    input wire logic fast_in,
    output logic win_ok_out,
    output logic [7:0] win_vec_out
);
    logic found_r, best_f_r, take;
    logic [3:0] best_p_r;
    logic [7:0] best_v_r;

    // Fast wins outright, else strictly higher level; equal levels keep
    // the earlier, smaller vector because the sweep runs upward.
    assign take = hit_in & (~found_r | (fast_in & ~best_f_r) |
                  (~best_f_r & ~fast_in & (prio_in > best_p_r)));

    // Publish at the end of each sweep, then restart the search.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            found_r <= 1'b0;
            best_f_r <= 1'b0;
            best_p_r <= 4'h0;
            best_v_r <= 8'h00;
            win_ok_out <= 1'b0;
            win_vec_out <= 8'h00;
        end else if (wrap_in) begin
            win_ok_out <= found_r | take;
            win_vec_out <= take ? scan_in : best_v_r;
            found_r <= 1'b0;
            best_f_r <= 1'b0;
            best_p_r <= 4'h0;
        end else if (take) begin
            found_r <= 1'b1;
            best_f_r <= fast_in;
            best_p_r <= prio_in;
            best_v_r <= scan_in;
        end
    end
endmodule

// file: irqd_top.sv
// Interrupt request detection top: source table, pending flags,
// destination routing, winner search and the register slave.
// Assumes all request lines are synchronous to core_clk_in (25 MHz)
// and that the bus master follows Avalon-MM waitrequest signalling.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "irqd_map.svh"
module irqd_top (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [255:0] periph_req_in,
    input wire logic [7:0] irq_pin_in,
    input wire logic cpu_ack_in,
    input wire logic dtc_start_in,
    input wire logic dma_start_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic cpu_irq_out,
    output logic [7:0] cpu_vec_out,
    output logic [31:0] cpu_vec_addr_out,
    output logic [31:0] fast_vector_pointer_out,
    output logic [31:0] nmi_table_out,
    output logic dtc_req_out,
    output logic [7:0] dtc_vec_out,
    output logic dma_req_out,
    output logic [7:0] dma_vec_out
);
    // ----------------------------------------------------------------
    // Source table
    // ----------------------------------------------------------------

    // Fixed detection kind per vector; peripherals cannot change it.
    function automatic irqd_pkg::irqd_kind_t kind_of(input int v);
        if (v inside {[64:71]})
            return irqd_pkg::IRQD_PIN;
        if (v inside {45, 46, 219, 220, 223, 224, 227, 228, 235, 236,
                      239, 240, 247, 248})
            return irqd_pkg::IRQD_SER;
        if (v inside {16, 21, [32:34], 44, 47, 57, 170, 171, 218, 221,
                      222, 225, 226, 229, 234, 237, 238, [241:246], 249})
            return irqd_pkg::IRQD_LEVEL;
        if (v inside {23, [27:31], 63, 88, 89, 92, 93, 102, 103, 106,
                      [114:141], [174:185], [198:201]})
            return irqd_pkg::IRQD_EDGE;
        return irqd_pkg::IRQD_RSV;
    endfunction

    // Whether the transfer controller may be activated by a vector.
    function automatic logic dtc_ok(input int v);
        return v inside {[27:31], 45, 46, [64:71], 102, 103, 106,
                         [114:117], 121, 122, 125, 126, [129:132],
                         [134:141], 174, 175, 177, 178, 180, 181, 183,
                         184, [198:201], 219, 220, 223, 224, 227, 228,
                         235, 236, 239, 240, 247, 248};
    endfunction

    // Whether a DMA channel may be activated by a vector.
    function automatic logic dma_ok(input int v);
        return v inside {[28:31], 45, 46, [64:67], 102, 103, 106, 114,
                         121, 125, 129, 134, 219, 220, 223, 224, 227,
                         228, 235, 236, 239, 240, 247, 248};
    endfunction

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------

    logic [31:0] ctrl_r;            // Post-transfer selects, fast source.
    logic [31:0] base_r;            // Relocatable vector table base.
    logic [15:0] sense_r;           // Two bits per external pin.
    logic [7:0] sel_r;              // Vector reached through VREG.
    logic [255:0] en_r;             // Request enable bits.
    logic [255:0] done_r;           // Transfer done, CPU interrupt owed.
    logic [3:0] prio_mem [0:255];   // Priority levels.
    logic [1:0] dest_mem [0:255];   // Chosen destinations.
    logic [7:0] pin_r;              // Pin input stage.
    logic [1:0] pdiv_r;             // Peripheral clock divider.
    logic pclk_en;                  // One-cycle peripheral clock enable.
    logic [7:0] scan_r;             // Sweep position of the searches.
    logic wait_r;                   // Registered waitrequest.

    // ----------------------------------------------------------------
    // Per-vector detection and routing
    // ----------------------------------------------------------------

    logic [255:0] pend;             // Pending flags.
    logic [255:0] clr;              // Clear strobes per vector.
    logic [255:0] to_cpu, to_dtc, to_dma;
    logic [255:0] el_cpu, el_dtc, el_dma;
    logic [7:0] fast_vec;
    logic dma_post, dtc_post, fast_en;
    logic bus_go, wr_go, sw_clr;
    logic [7:0] sel_w;

    assign fast_vec = ctrl_r[15:8];
    assign fast_en = ctrl_r[`IRQD_CTRL_FAST_EN];
    assign dma_post = ctrl_r[`IRQD_CTRL_DMA_POST];
    assign dtc_post = ctrl_r[`IRQD_CTRL_DTC_POST];
    // The peripheral clock runs at a fixed fraction of the system clock.
    assign pclk_en = (pdiv_r == `IRQD_PCLK_DIV);

    genvar gv;
    generate
        for (gv = 0; gv < `IRQD_NV; gv++) begin : g_src
            localparam irqd_pkg::irqd_kind_t KIND = kind_of(gv);
            localparam logic DTC_OK = dtc_ok(gv);
            localparam logic DMA_OK = dma_ok(gv);
            localparam logic DLY = (gv >= `IRQD_DLY_LO) &&
                                   (gv <= `IRQD_DLY_HI);
            logic req;
            logic [1:0] sense;
            // Pins enter through the input stage, other lines directly.
            if (KIND == irqd_pkg::IRQD_PIN) begin : g_pin
                assign req = pin_r[gv - `IRQD_PIN_LO];
                assign sense = sense_r[2*(gv-`IRQD_PIN_LO) +: 2];
            end else begin : g_per
                assign req = periph_req_in[gv];
                assign sense = 2'h0;
            end
            // A disabled peripheral simply stops driving; an edge flag is
            // not touched by that, a level flag follows the line.
            irqd_det u_det (
                .core_clk_in(core_clk_in),
                .nrst_in(nrst_in),
                .req_in(req),
                .kind_in(KIND),
                .sense_in(sense),
                .dly_in(DLY),
                .pclk_en_in(pclk_en),
                .clr_in(clr[gv]),
                .pend_out(pend[gv])
            );
            // One destination only; a choice the source lacks, or a
            // finished transfer, falls back to the processor.
            assign to_dtc[gv] = (dest_mem[gv] == irqd_pkg::IRQD_TO_DTC) &
                                DTC_OK & ~done_r[gv];
            assign to_dma[gv] = (dest_mem[gv] == irqd_pkg::IRQD_TO_DMA) &
                                DMA_OK & ~done_r[gv];
            assign to_cpu[gv] = ~to_dtc[gv] & ~to_dma[gv] &
                                (KIND != irqd_pkg::IRQD_RSV);
            // Enable gates forwarding only.
            assign el_cpu[gv] = pend[gv] & en_r[gv] & to_cpu[gv];
            assign el_dtc[gv] = pend[gv] & en_r[gv] & to_dtc[gv];
            assign el_dma[gv] = pend[gv] & en_r[gv] & to_dma[gv];
            // Acceptance clears edge flags; level flags ignore it.
            // DMA/TRANSFER_CONTROLLER start clears unless a CPU interrupt follows.
            assign clr[gv] = (sw_clr & (sel_r == 8'(gv))) |
                (cpu_ack_in & cpu_irq_out & (cpu_vec_out == 8'(gv))) |
                (dtc_start_in & dtc_req_out & ~dtc_post &
                 (dtc_vec_out == 8'(gv))) |
                (dma_start_in & dma_req_out & ~dma_post &
                 (dma_vec_out == 8'(gv)));
        end
    endgenerate

    // ----------------------------------------------------------------
    // Winner search, one sweep of 256 cycles per destination
    // ----------------------------------------------------------------

    logic wrap, cpu_ok, dtc_ok_w, dma_ok_w;
    logic [7:0] cpu_win, dtc_win, dma_win;
    assign wrap = (scan_r == 8'hFF);

    // The processor search honours fast source and level.
    irqd_arb u_arb_cpu (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .scan_in(scan_r),
        .wrap_in(wrap),
        .hit_in(el_cpu[scan_r]),
        .prio_in(prio_mem[scan_r]),
        .fast_in(fast_en & (fast_vec == scan_r)),
        .win_ok_out(cpu_ok),
        .win_vec_out(cpu_win)
    );
    // Transfer searches ignore levels: smaller vector wins.
    irqd_arb u_arb_dtc (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .scan_in(scan_r),
        .wrap_in(wrap),
        .hit_in(el_dtc[scan_r]),
        .prio_in(4'h0),
        .fast_in(1'b0),
        .win_ok_out(dtc_ok_w),
        .win_vec_out(dtc_win)
    );
    irqd_arb u_arb_dma (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .scan_in(scan_r),
        .wrap_in(wrap),
        .hit_in(el_dma[scan_r]),
        .prio_in(4'h0),
        .fast_in(1'b0),
        .win_ok_out(dma_ok_w),
        .win_vec_out(dma_win)
    );

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------

    logic [31:0] rd_w, vreg_w, stat_w;
    // A request is answered one cycle after it appears; the write acts
    // on the edge where the master sees waitrequest low.
    assign bus_go = (avs_read_in | avs_write_in) & ~wait_r;
    assign wr_go = avs_write_in & ~wait_r;
    assign sel_w = sel_r;
    // Writing a zero pending bit clears an edge flag.
    assign sw_clr = wr_go & (avs_address_in == `IRQD_OFS_VREG) &
                    ~avs_writedata_in[0];
    assign vreg_w = {20'h00000, prio_mem[sel_w], 4'h0,
                     dest_mem[sel_w], en_r[sel_w], pend[sel_w]};
    assign stat_w = {23'h000000, cpu_irq_out, cpu_vec_out};
    // Unmapped offsets read zero and ignore writes.
    assign rd_w = (avs_address_in == `IRQD_OFS_CTRL) ? ctrl_r :
                  (avs_address_in == `IRQD_OFS_BASE) ? base_r :
                  (avs_address_in == `IRQD_OFS_SENSE) ?
                      {16'h0000, sense_r} :
                  (avs_address_in == `IRQD_OFS_SEL) ? {24'h000000, sel_r} :
                  (avs_address_in == `IRQD_OFS_VREG) ? vreg_w :
                  (avs_address_in == `IRQD_OFS_STAT) ? stat_w : 32'h0;

    // Handshake and read data; waitrequest idles high.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_r <= 1'b1;
            avs_readdata_out <= 32'h0;
        end else begin
            wait_r <= ~((avs_read_in | avs_write_in) & wait_r);
            if ((avs_read_in | avs_write_in) & wait_r)
                avs_readdata_out <= rd_w;
        end
    end
    assign avs_waitrequest_out = wait_r;

    // Writable registers.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_r <= 32'h0;
            base_r <= `IRQD_BASE_RST;
            sense_r <= `IRQD_SENSE_RST;
            sel_r <= 8'h00;
        end else if (wr_go) begin
            if (avs_address_in == `IRQD_OFS_CTRL)
                ctrl_r <= avs_writedata_in & 32'h0001FF03;
            if (avs_address_in == `IRQD_OFS_BASE)
                base_r <= {avs_writedata_in[31:2], 2'h0};
            if (avs_address_in == `IRQD_OFS_SENSE)
                sense_r <= avs_writedata_in[15:0];
            if (avs_address_in == `IRQD_OFS_SEL)
                sel_r <= avs_writedata_in[7:0];
        end
    end

    // Per-vector tables; memories carry no reset, enables do.
    always_ff @(posedge core_clk_in) begin
        if (wr_go & (avs_address_in == `IRQD_OFS_VREG)) begin
            prio_mem[sel_r] <= avs_writedata_in[11:8];
            dest_mem[sel_r] <= avs_writedata_in[3:2];
        end
    end

    // ----------------------------------------------------------------
    // Dynamic state and outputs
    // ----------------------------------------------------------------

    // Enables, done marks, divider, sweep and the pin input stage.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            en_r <= '0;
            done_r <= '0;
            pdiv_r <= 2'h0;
            scan_r <= 8'h00;
            pin_r <= 8'h00;
        end else begin
            if (wr_go & (avs_address_in == `IRQD_OFS_VREG))
                en_r[sel_r] <= avs_writedata_in[1];
            // A transfer with the post option owes a processor
            // interrupt; the mark goes once the flag has cleared.
            done_r <= (done_r & pend) |
                ({256{dtc_start_in & dtc_req_out & dtc_post}} &
                 (256'h1 << dtc_vec_out)) |
                ({256{dma_start_in & dma_req_out & dma_post}} &
                 (256'h1 << dma_vec_out));
            pdiv_r <= pclk_en ? 2'h0 : pdiv_r + 2'h1;
            scan_r <= scan_r + 8'h01;
            pin_r <= irq_pin_in;
        end
    end

    // Requests drop as soon as the winning flag is gone, so a served
    // vector is not offered twice while the next sweep runs.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cpu_irq_out <= 1'b0;
            cpu_vec_out <= 8'h00;
            cpu_vec_addr_out <= 32'h0;
            fast_vector_pointer_out <= 32'h0;
            nmi_table_out <= 32'h0;
            dtc_req_out <= 1'b0;
            dtc_vec_out <= 8'h00;
            dma_req_out <= 1'b0;
            dma_vec_out <= 8'h00;
        end else begin
            cpu_irq_out <= cpu_ok & el_cpu[cpu_win] & ~clr[cpu_win];
            cpu_vec_out <= cpu_win;
            cpu_vec_addr_out <= base_r + {22'h0, cpu_win, 2'h0};
            fast_vector_pointer_out <= base_r +
                {22'h0, fast_vec, 2'h0};
            nmi_table_out <= `IRQD_NMI_TABLE;
            dtc_req_out <= dtc_ok_w & el_dtc[dtc_win] & ~clr[dtc_win];
            dtc_vec_out <= dtc_win;
            dma_req_out <= dma_ok_w & el_dma[dma_win] & ~clr[dma_win];
            dma_vec_out <= dma_win;
        end
    end
endmodule

// file: irqd_far.sv
// Far-side consumer model: processor, transfer controller or DMA engine.
// Assumes a level request from the detection block, one clock domain.
`timescale 1ns/10ps
module irqd_far (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic req_in,
    input wire logic en_in,
    input wire logic [3:0] dly_in,
    output logic start_out
);
    logic [3:0] wait_r; // Cycles the request has stood so far.
    logic done_r; // Taken once; kept until the request drops.
    // One start pulse per request, dly_in + 1 cycles after it rises.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_r <= 4'h0;
            done_r <= 1'b0;
            start_out <= 1'b0;
        end else begin
            start_out <= req_in && en_in && !done_r && !start_out
                && wait_r == dly_in;
            done_r <= req_in && (done_r || start_out);
            wait_r <= (req_in && en_in && wait_r != dly_in) ? wait_r + 4'h1
                : (req_in && en_in ? wait_r : 4'h0);
        end
    end
endmodule

// file: irqd_chk.sv
// Checker of the detection top, bound to it below.
// Assumes software leaves the vector table base at its reset value.
`timescale 1ns/10ps
module irqd_chk (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic avs_waitrequest_out,
    input wire logic cpu_irq_out,
    input wire logic cpu_ack_in,
    input wire logic [7:0] cpu_vec_out,
    input wire logic [31:0] cpu_vec_addr_out,
    input wire logic [31:0] fast_vector_pointer_out,
    input wire logic [31:0] nmi_table_out,
    input wire logic dma_req_out,
    input wire logic dma_start_in,
    input wire logic [7:0] dma_vec_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic [7:0] fast_r; // Fast vector as software last wrote it.
    wire logic ctrl_wr = avs_write_in && !avs_waitrequest_out
        && avs_address_in == 8'h00;
    // Shadow of the fast vector field, taken at the completing edge.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) fast_r <= 8'h00;
        else if (ctrl_wr) fast_r <= avs_writedata_in[15:8];
    end
    sequence req_wait_s;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    wait_one_a: assert property (req_wait_s |=> !avs_waitrequest_out)
        else $error("Bus wait not one cycle");
    wait_end_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("Bus ready held too long");
    nmi_fixed_a: assert property ($past(nrst_in) |->
        nmi_table_out == 32'hFFFFFFF8) else $error("NMI table moved");
    vec_addr_a: assert property (cpu_irq_out |->
        cpu_vec_addr_out == {22'h0, cpu_vec_out, 2'h0})
        else $error("Vector address wrong");
    fast_ptr_a: assert property (ctrl_wr |-> ##2
        fast_vector_pointer_out == {22'h0, fast_r, 2'h0})
        else $error("Fast pointer wrong");
    ack_clr_a: assert property (cpu_irq_out && cpu_ack_in |->
        ##[1:8] !cpu_irq_out) else $error("Request kept after accept");
    dma_clr_a: assert property (dma_req_out && dma_start_in |->
        ##[1:8] !dma_req_out) else $error("DMA request kept after start");
    one_dest_a: assert property (!(cpu_irq_out && dma_req_out
        && cpu_vec_out == dma_vec_out)) else $error("Two destinations");
    rsv_vec_a: assert property (cpu_irq_out |->
        !(cpu_vec_out inside {8'h11, 8'h48, 8'hFF}))
        else $error("Reserved vector forwarded");
endmodule
bind irqd_top irqd_chk chk_i (.*);

// file: irqd_top_tb.sv
// Testbench of the detection top: bus tasks and directed sequences.
// Assumes the checker is bound; the table base stays at reset.
`timescale 1ns/10ps
module irqd_top_tb;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [255:0] periph_req_in = '0;
    logic [7:0] irq_pin_in = 8'hFF; // Idle high: low-level sense is off.
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out, cpu_vec_addr_out, rd;
    logic [31:0] fast_vector_pointer_out, nmi_table_out;
    logic avs_waitrequest_out, cpu_irq_out, dtc_req_out, dma_req_out;
    logic cpu_ack_in, dtc_start_in, dma_start_in;
    logic [7:0] cpu_vec_out, dtc_vec_out, dma_vec_out;
    logic [2:0] far_en = 3'h0; // Consumers that answer: dma, dtc, cpu.
    wire logic [2:0] outs = {dma_req_out, dtc_req_out, cpu_irq_out};
    int error_cnt = 0;
    int comparisons = 0;
    always #20 core_clk_in = ~core_clk_in;
    irqd_top uut (.*);
    irqd_far cpu_m (.core_clk_in, .nrst_in, .req_in(cpu_irq_out),
        .en_in(far_en[0]), .dly_in(4'h2), .start_out(cpu_ack_in));
    irqd_far dtc_m (.core_clk_in, .nrst_in, .req_in(dtc_req_out),
        .en_in(far_en[1]), .dly_in(4'h9), .start_out(dtc_start_in));
    irqd_far dma_m (.core_clk_in, .nrst_in, .req_in(dma_req_out),
        .en_in(far_en[2]), .dly_in(4'h0), .start_out(dma_start_in));
    task automatic stop_test();
        $display("Mismatches %0d in %0d compares", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One word transfer; held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (n == 50) begin
            chk(0, 1);
            stop_test();
        end
    endtask
    task automatic vreg(input logic [7:0] v, input logic [31:0] d);
        bus(1, 8'h0C, {24'h0, v});
        bus(1, 8'h10, d);
    endtask
    task automatic pend(input logic [7:0] v);
        bus(1, 8'h0C, {24'h0, v});
        bus(0, 8'h10, 32'h0);
    endtask
    // Each level lasts four cycles, twice the slow clock period.
    task automatic pulse(input int v);
        periph_req_in[v] <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        periph_req_in[v] <= 1'b0;
        repeat (4) @(posedge core_clk_in);
    endtask
    task automatic wait_for(input int k, input logic lvl);
        int n;
        n = 0;
        while (outs[k] !== lvl && n < 1200) begin
            @(posedge core_clk_in);
            n++;
        end
        if (n == 1200) begin
            chk(0, 1);
            stop_test();
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        chk(nmi_table_out, 32'hFFFFFFF8);
        bus(1, 8'h00, 32'h00011F00);
        repeat (3) @(posedge core_clk_in);
        chk(fast_vector_pointer_out, 32'h7C);
        vreg(28, 32'h100);
        pulse(28);
        pulse(28);
        pend(28);
        chk(rd[0], 1);
        repeat (520) @(posedge core_clk_in);
        chk(cpu_irq_out, 0);
        vreg(28, 32'h103);
        wait_for(0, 1);
        chk(cpu_vec_addr_out, 32'h70);
        far_en <= 3'h1;
        wait_for(0, 0);
        pend(28);
        chk(rd[0], 0);
        // Equal levels first, then a higher level and the fast source.
        for (int r = 0; r < 2; r++) begin
            far_en <= 3'h0;
            vreg(29, 32'h102);
            vreg(30, r ? 32'h202 : 32'h102);
            vreg(31, 32'h102);
            periph_req_in[31:29] <= r ? 3'h7 : 3'h3;
            repeat (4) @(posedge core_clk_in);
            periph_req_in[31:29] <= 3'h0;
            wait_for(0, 1);
            repeat (600) @(posedge core_clk_in);
            chk(32'(cpu_vec_out), r ? 32'd31 : 32'd29);
            far_en <= 3'h1;
            repeat (1600) @(posedge core_clk_in);
            chk(cpu_irq_out, 0);
        end
        vreg(45, 32'h100);
        pulse(45);
        pulse(45);
        vreg(45, 32'h100);
        pend(45);
        chk(rd[0], 1);
        vreg(45, 32'h100);
        pend(45);
        chk(rd[0], 0);
        vreg(16, 32'h100);
        periph_req_in[16] <= 1'b1;
        vreg(16, 32'h100);
        pend(16);
        chk(rd[0], 1);
        periph_req_in[16] <= 1'b0;
        pend(16);
        chk(rd[0], 0);
        pulse(17);
        pend(17);
        chk(rd[0], 0);
        bus(0, 8'h3C, 32'h0);
        chk(rd, 0);
        for (int k = 1; k < 3; k++) begin
            vreg(114, 32'h102 + 32'(4 * k));
            pulse(114);
            wait_for(k, 1);
            chk(cpu_irq_out, 0);
            far_en <= 3'(1 << k);
            wait_for(k, 0);
            pend(114);
            chk(rd[0], 0);
        end
        for (int m = 0; m < 4; m++) begin
            bus(1, 8'h08, 32'(m));
            vreg(64, 32'h100);
            irq_pin_in[0] <= 1'b0;
            @(posedge core_clk_in);
            bus(0, 8'h10, 32'h0);
            chk(rd[0], 0);
            repeat (12) @(posedge core_clk_in);
            bus(0, 8'h10, 32'h0);
            chk(rd[0], m != 2);
            irq_pin_in[0] <= 1'b1;
            repeat (12) @(posedge core_clk_in);
            bus(0, 8'h10, 32'h0);
            chk(rd[0], m != 0);
        end
        stop_test();
    end
endmodule
